// ---- adc_pkg.sv ----
package adc_pkg;

   typedef enum logic {
      CODING_TWOS   = 1'b0,
      CODING_BINARY = 1'b1
   } coding_t;

   typedef logic [7:0] code_t;

endpackage : adc_pkg

// ---- adc_regs.svh ----
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// Register byte offsets
`define ADC_CTRL_OFS      12'h000
`define ADC_STATUS_OFS    12'h004
`define ADC_IRQ_STAT_OFS  12'h008
`define ADC_IRQ_EN_OFS    12'h00C
`define ADC_IRQ_CLR_OFS   12'h010
`define ADC_COUNT_OFS     12'h014

// Control fields
`define ADC_CTRL_RUN_BIT  0
`define ADC_CTRL_RST      32'h0000_0001

// Status fields
`define ADC_STAT_WORD_LSB 0
`define ADC_STAT_FLAG_BIT 8
`define ADC_STAT_TC_BIT   9
`define ADC_STAT_OE_BIT   10

// Interrupt event bits
`define ADC_IRQ_SAMPLE    0
`define ADC_IRQ_RANGE     1
`define ADC_IRQ_RATE      2
`define ADC_IRQ_W         3
`define ADC_IRQ_EN_RST    3'h0

// Digitised analog level and convertible window
`define ADC_ANA_W         10
`define ADC_ANA_STEP0     10'h080
`define ADC_ANA_STEP255   10'h17F
`define ADC_CODE_MAX      8'hFF
`define ADC_CODE_MIN      8'h00

// Timing
`define ADC_CLK_PERIOD_NS 10
`define ADC_MAX_RATE_MHZ  40
`define ADC_MIN_PERIOD_NS (1000 / `ADC_MAX_RATE_MHZ)
`define ADC_RATE_MIN_CYC  (`ADC_MIN_PERIOD_NS / `ADC_CLK_PERIOD_NS)

`endif

// ---- adc_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"
module adc_source_model (
   input  wire logic                  clk,
   output logic                       sample_clk,
   output logic                       sample_clk_n,
   output logic [`ADC_ANA_W-1:0]      analog_input
);
   initial begin
      sample_clk   = 1'b0;
      sample_clk_n = 1'b1;
      analog_input = '0;
   end
   // Frames are 11 cycles apart, far below the top sampling rate
   task automatic convert(input logic [`ADC_ANA_W-1:0] lvl,
                          input logic comp);
      @(posedge clk);
      analog_input <= lvl;
      repeat (3) @(posedge clk);
      if (comp) begin
         sample_clk_n <= 1'b0;
      end else begin
         sample_clk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      // Hold is over: show the inverse so a late capture is caught
      analog_input <= ~lvl;
      sample_clk   <= 1'b0;
      sample_clk_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : convert
endmodule : adc_source_model
`default_nettype wire

// ---- adc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_ff;

   // Stage one feeds only stage two
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff  <= '0;
         sync_out <= '0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule : adc_sync

`default_nettype wire

// ---- video_adc_output_interface.sv ----
// Overview of operation
// - Sample on rising edge of true clock
// - Sample on falling edge of complement clock
// - AC drive: same edges, true/complement
// - Low coding select gives two's complement
// - Active-low enable drives data and flag
// - Separate flag marks out-of-range input
// - Eight-bit word, bit 7 most significant
// - Up to 40 MHz; faster is flagged (the code flags only edges one clock apart)
// - Enabled: coding select picks output code
// - Disabled: word and flag high impedance
// - Under: code 0, over: 255, flag set (in two's complement the code gives 128 and 127)
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module video_adc_output_interface (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  sample_clk,
   input  wire logic                  sample_clk_n,
   input  wire logic                  coding_select_n,
   input  wire logic                  chip_enable_n,
   input  wire logic [`ADC_ANA_W-1:0] analog_input,
   output logic      [7:0]            sample_word,
   output logic                       sample_word_oe_n,
   output logic                       range_flag,
   output logic                       range_flag_oe_n,
   output logic                       irq
);

   localparam int SW = 4 + `ADC_ANA_W;
   localparam logic [3:0] RATE_MIN = 4'(`ADC_RATE_MIN_CYC);

   logic [SW-1:0]           pins_sync;
   logic                    clk_t_s;
   logic                    clk_c_s;
   logic                    tc_n_s;
   logic                    ce_n_s;
   logic [`ADC_ANA_W-1:0]   ana_s;
   logic                    clk_t_prev_ff;
   logic                    clk_c_prev_ff;
   logic                    edge_hit;
   logic                    run_ff;
   logic                    take;
   logic [3:0]              gap_ff;
   logic                    rate_err;
   adc_pkg::code_t          code_bin;
   logic                    out_of_range;
   adc_pkg::code_t          sample_word_ff;
   logic                    range_flag_ff;
   logic                    oe_n_ff;
   logic [31:0]             count_ff;
   logic [`ADC_IRQ_W-1:0]   irq_stat_ff;
   logic [`ADC_IRQ_W-1:0]   nxt_irq_stat;
   logic [`ADC_IRQ_W-1:0]   irq_en_ff;
   logic [`ADC_IRQ_W-1:0]   irq_evt;
   logic [`ADC_IRQ_W-1:0]   irq_clr;
   logic                    irq_ff;
   logic [31:0]             prdata_ff;
   logic                    pready_ff;
   logic                    pslverr_ff;
   logic                    setup;
   logic                    wr_done;
   logic                    addr_ok;
   logic [31:0]             rd_mux;
   adc_pkg::coding_t        coding;

   // Pins cross into clk through two flops before anything looks at them
   // Idle-high pins enter inverted: the cleared synchroniser then reads
   // as idle, so reset gives no false edge and no driven outputs
   adc_sync #(
      .W (SW)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({sample_clk, ~sample_clk_n, coding_select_n,
                  ~chip_enable_n, analog_input}),
      .sync_out (pins_sync)
   );

   assign clk_t_s = pins_sync[SW-1];
   assign clk_c_s = ~pins_sync[SW-2];
   assign tc_n_s  = pins_sync[SW-3];
   assign ce_n_s  = ~pins_sync[SW-4];
   assign ana_s   = pins_sync[`ADC_ANA_W-1:0];
   assign coding  = adc_pkg::coding_t'(tc_n_s);

   always_ff @(posedge clk) begin
      if (rst) begin
         clk_t_prev_ff <= 1'b0;
         clk_c_prev_ff <= 1'b1;
      end else begin
         clk_t_prev_ff <= clk_t_s;
         clk_c_prev_ff <= clk_c_s;
      end
   end

   // The undriven input is held static, so only the driven one makes edges
   assign edge_hit = (clk_t_s & ~clk_t_prev_ff)
                   | (~clk_c_s & clk_c_prev_ff);
   assign take     = edge_hit & run_ff;

   // Edges closer than the minimum period mean the partner overclocks
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_ff <= 4'hF;
      end else if (edge_hit) begin
         gap_ff <= 4'h1;
      end else if (gap_ff != 4'hF) begin
         gap_ff <= gap_ff + 4'h1;
      end
   end

   assign rate_err = edge_hit && (gap_ff < RATE_MIN);

   // Clamp to the end codes outside the convertible window
   always_comb begin
      out_of_range = 1'b0;
      code_bin     = `ADC_CODE_MIN;
      if (ana_s < `ADC_ANA_STEP0) begin
         out_of_range = 1'b1;
         code_bin     = `ADC_CODE_MIN;
      end else if (ana_s > `ADC_ANA_STEP255) begin
         out_of_range = 1'b1;
         code_bin     = `ADC_CODE_MAX;
      end else begin
         code_bin = 8'(ana_s - `ADC_ANA_STEP0);
      end
   end

   // One word per edge while run is set, one clock after the synchronised edge
   always_ff @(posedge clk) begin
      if (rst) begin
         sample_word_ff <= `ADC_CODE_MIN;
         range_flag_ff  <= 1'b0;
      end else if (take) begin
         // Two's complement flips only the msb of the binary code
         if (coding == adc_pkg::CODING_TWOS) begin
            sample_word_ff <= {~code_bin[7], code_bin[6:0]};
         end else begin
            sample_word_ff <= code_bin;
         end
         range_flag_ff <= out_of_range;
      end
   end

   // Enable acts on word and flag alike, coding select ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         oe_n_ff <= 1'b1;
      end else begin
         oe_n_ff <= ce_n_s;
      end
   end

   assign sample_word      = sample_word_ff;
   assign range_flag       = range_flag_ff;
   assign sample_word_oe_n = oe_n_ff;
   assign range_flag_oe_n  = oe_n_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         count_ff <= 32'h0000_0000;
      end else if (take) begin
         count_ff <= count_ff + 32'h0000_0001;
      end
   end

   // APB slave: read data is latched in setup, answer with no wait state
   assign setup   = psel & ~penable;
   assign wr_done = psel & penable & pready_ff & pwrite;
   assign addr_ok = (paddr == `ADC_CTRL_OFS)     ||
                    (paddr == `ADC_STATUS_OFS)   ||
                    (paddr == `ADC_IRQ_STAT_OFS) ||
                    (paddr == `ADC_IRQ_EN_OFS)   ||
                    (paddr == `ADC_IRQ_CLR_OFS)  ||
                    (paddr == `ADC_COUNT_OFS);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `ADC_CTRL_OFS: begin
            rd_mux[`ADC_CTRL_RUN_BIT] = run_ff;
         end
         `ADC_STATUS_OFS: begin
            rd_mux[`ADC_STAT_WORD_LSB +: 8] = sample_word_ff;
            rd_mux[`ADC_STAT_FLAG_BIT]      = range_flag_ff;
            rd_mux[`ADC_STAT_TC_BIT]        = tc_n_s;
            rd_mux[`ADC_STAT_OE_BIT]        = ~oe_n_ff;
         end
         `ADC_IRQ_STAT_OFS: begin
            rd_mux[`ADC_IRQ_W-1:0] = irq_stat_ff;
         end
         `ADC_IRQ_EN_OFS: begin
            rd_mux[`ADC_IRQ_W-1:0] = irq_en_ff;
         end
         `ADC_COUNT_OFS: begin
            rd_mux = count_ff;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else if (setup) begin
         pready_ff  <= 1'b1;
         pslverr_ff <= ~addr_ok;
         prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         run_ff <= 1'(`ADC_CTRL_RST);
      end else if (wr_done && paddr == `ADC_CTRL_OFS) begin
         run_ff <= pwdata[`ADC_CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_en_ff <= `ADC_IRQ_EN_RST;
      end else if (wr_done && paddr == `ADC_IRQ_EN_OFS) begin
         irq_en_ff <= pwdata[`ADC_IRQ_W-1:0];
      end
   end

   // Sticky events; a new event in the clearing cycle survives
   always_comb begin
      irq_evt                  = '0;
      irq_evt[`ADC_IRQ_SAMPLE] = take;
      irq_evt[`ADC_IRQ_RANGE]  = take & out_of_range;
      irq_evt[`ADC_IRQ_RATE]   = rate_err;
      irq_clr = '0;
      if (wr_done && paddr == `ADC_IRQ_CLR_OFS) begin
         irq_clr = pwdata[`ADC_IRQ_W-1:0];
      end
      nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat_ff <= '0;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_ff      <= |(nxt_irq_stat & irq_en_ff);
      end
   end

   assign irq = irq_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_rise_takes_word: assert property (
      (clk_t_s && !clk_t_prev_ff && run_ff)
      |=> (count_ff == $past(count_ff) + 32'h0000_0001))
      else $error("true clock rise did not produce a word");

   a_fall_takes_word: assert property (
      (!clk_c_s && clk_c_prev_ff && run_ff)
      |=> (count_ff == $past(count_ff) + 32'h0000_0001))
      else $error("complement clock fall did not produce a word");

   a_one_word_edge: assert property (
      !take |=> (sample_word_ff == $past(sample_word_ff)
                 && range_flag_ff == $past(range_flag_ff)))
      else $error("output word changed without a sampling edge");

   a_twos_coding: assert property (
      (take && !tc_n_s && !out_of_range)
      |=> (sample_word_ff == {~$past(code_bin[7]), $past(code_bin[6:0])}))
      else $error("two's complement word wrong");

   a_binary_coding: assert property (
      (take && tc_n_s) |=> (sample_word_ff == $past(code_bin)))
      else $error("binary word wrong");

   a_under_code: assert property (
      (take && tc_n_s && ana_s < `ADC_ANA_STEP0)
      |=> (sample_word_ff == `ADC_CODE_MIN && range_flag_ff))
      else $error("underflow code or flag wrong");

   a_over_code: assert property (
      (take && ana_s > `ADC_ANA_STEP255)
      |=> range_flag_ff)
      else $error("overflow flag not set");

   a_over_word: assert property (
      (take && tc_n_s && ana_s > `ADC_ANA_STEP255)
      |=> (sample_word_ff == `ADC_CODE_MAX))
      else $error("overflow code wrong");

   a_count_hold: assert property (
      !take |=> (count_ff == $past(count_ff)))
      else $error("sample count moved without an edge");

   a_in_range: assert property (
      (take && !out_of_range) |=> !range_flag_ff)
      else $error("flag set inside range");

   a_disable_hiz: assert property (
      ce_n_s |=> (sample_word_oe_n && range_flag_oe_n))
      else $error("outputs driven while disabled");

   a_enable_drive: assert property (
      $fell(ce_n_s) |=> (!sample_word_oe_n && !range_flag_oe_n))
      else $error("outputs not driven after enable");

   a_rate_flag: assert property (
      (edge_hit && $past(edge_hit)) |=> irq_stat_ff[`ADC_IRQ_RATE])
      else $error("back to back edges not flagged");

   c_binary_word: cover property (take && tc_n_s && !ce_n_s);
   c_twos_word:   cover property (take && !tc_n_s && !ce_n_s);
   c_range_word:  cover property (take && out_of_range);
   c_irq_raise:   cover property (!irq ##1 irq);
   c_rate_error:  cover property (rate_err);

endmodule : video_adc_output_interface

`default_nettype wire

// ---- video_adc_output_interface_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"
module video_adc_output_interface_test;
   logic                  clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0]           paddr;
   logic [31:0]           pwdata, prdata, rd;
   logic                  sample_clk, sample_clk_n, coding_select_n;
   logic                  chip_enable_n, sample_word_oe_n, range_flag;
   logic                  range_flag_oe_n, irq, rerr, csn;
   logic [`ADC_ANA_W-1:0] analog_input, lvl;
   logic [7:0]            sample_word;
   logic [8:0]            last;
   logic [15:0]           lfsr;
   logic [9:0]            corner [8];
   int                    bad_count, tests_run;

   video_adc_output_interface i_video_adc_output_interface (
      .clk              (clk),
      .rst              (rst),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .paddr            (paddr),
      .pwdata           (pwdata),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .sample_clk       (sample_clk),
      .sample_clk_n     (sample_clk_n),
      .coding_select_n  (coding_select_n),
      .chip_enable_n    (chip_enable_n),
      .analog_input     (analog_input),
      .sample_word      (sample_word),
      .sample_word_oe_n (sample_word_oe_n),
      .range_flag       (range_flag),
      .range_flag_oe_n  (range_flag_oe_n),
      .irq              (irq)
   );
   adc_source_model i_adc_source_model (.clk(clk), .sample_clk(sample_clk),
      .sample_clk_n(sample_clk_n), .analog_input(analog_input));

   always #5 clk = ~clk;

   function automatic logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : next_rand

   function automatic logic [8:0] expect_out(input logic [9:0] l,
                                             input logic c);
      logic [7:0] b;
      logic       f;
      f = (l < `ADC_ANA_STEP0) || (l > `ADC_ANA_STEP255);
      b = (l < `ADC_ANA_STEP0) ? `ADC_CODE_MIN :
          (l > `ADC_ANA_STEP255) ? `ADC_CODE_MAX : 8'(l - `ADC_ANA_STEP0);
      if (!c) b[7] = ~b[7];
      return {f, b};
   endfunction : expect_out

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic wrap_up;
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Ready, read data and error are taken at the completing edge itself
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd      = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         $display("unexpected at %0t: no ready", $time);
         wrap_up();
      end
   endtask : apb

   task automatic sample(input logic [9:0] l, input logic c, input logic m);
      @(posedge clk);
      coding_select_n <= c;
      i_adc_source_model.convert(l, m);
      #1;
   endtask : sample

   initial begin
      clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; coding_select_n = 1; chip_enable_n = 1;
      lfsr = 16'h0141; bad_count = 0; tests_run = 0;
      corner = '{10'h000, 10'h07F, 10'h080, 10'h081,
                 10'h17E, 10'h17F, 10'h180, 10'h3FF};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check({irq, sample_word_oe_n, range_flag_oe_n}, 32'h3);
      apb(1'b0, `ADC_CTRL_OFS, '0);
      check(rd, `ADC_CTRL_RST);
      apb(1'b0, `ADC_IRQ_EN_OFS, '0);
      check(rd, 32'h0);
      apb(1'b0, 12'hFFC, '0);
      check({rerr, rd[30:0]}, 32'h8000_0000);
      chip_enable_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1 check({sample_word_oe_n, range_flag_oe_n}, 32'h0);
      apb(1'b1, `ADC_IRQ_EN_OFS, 32'h3);
      for (int i = 0; i < 32; i++) begin
         lfsr = next_rand(lfsr);
         lvl = (i < 8) ? corner[i] : 10'(lfsr[8:0]) + 10'h040;
         csn = lfsr[10];
         sample(lvl, csn, lfsr[11]);
         last = expect_out(lvl, csn);
         check({range_flag, sample_word}, last);
      end
      apb(1'b0, `ADC_COUNT_OFS, '0);
      check(rd, 32'd32);
      apb(1'b0, `ADC_STATUS_OFS, '0);
      check(rd[8:0], last);
      check(irq, 32'h1);
      apb(1'b0, `ADC_IRQ_STAT_OFS, '0);
      check(rd, 32'h3);
      apb(1'b1, `ADC_IRQ_CLR_OFS, 32'h7);
      repeat (2) @(posedge clk);
      #1 check(irq, 32'h0);
      apb(1'b1, `ADC_IRQ_EN_OFS, 32'h0);
      sample(10'h100, 1'b1, 1'b1);
      check({irq, range_flag, sample_word}, 32'h080);
      apb(1'b0, `ADC_IRQ_STAT_OFS, '0);
      check(rd, 32'h1);
      // With run cleared a pin edge must leave the word alone
      apb(1'b1, `ADC_CTRL_OFS, 32'h0);
      sample(10'h3FF, 1'b1, 1'b0);
      check({range_flag, sample_word}, 32'h080);
      apb(1'b0, `ADC_COUNT_OFS, '0);
      check(rd, 32'd33);
      chip_enable_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check({sample_word_oe_n, range_flag_oe_n}, 32'h3);
      wrap_up();
   end
endmodule : video_adc_output_interface_test
`default_nettype wire
